// ---- verilog/serial_config_power_reset_regs.sv ----
// Serial configuration, power-down and reset control register group
`timescale 1ns/1ps

module serial_config_power_reset_regs (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_rvalid_out,
  input  wire logic        update_pin_in,
  input  wire logic        power_down_pin_in,
  input  wire logic [3:0]  startup_pin_in,
  output logic [3:0]       startup_latched_out,
  output logic             update_pulse_out,
  output logic             readback_pending_out,
  output logic             soft_reset_out,
  output logic             lsb_first_out,
  output logic             sdo_enable_out,
  output logic             diff_driver_pd_out,
  output logic             cmos_driver_en_out,
  output logic             doubler_power_out,
  output logic             multiplier_pd_out,
  output logic             reference_a_pd_out,
  output logic             reference_b_pd_out,
  output logic             full_power_down_out,
  output logic             system_clock_stop_out,
  output logic             digital_clock_gate_out,
  output logic             history_clear_out,
  output logic             interrupt_clear_out,
  output logic             fine_detector_rst_out,
  output logic             coarse_detector_rst_out,
  output logic             loop_filter_rst_out,
  output logic             comb_integrator_rst_out,
  output logic             synthesizer_rst_out,
  output logic             fundamental_pd_out,
  output logic             feedback_prescaler_rst_out,
  output logic             input_prescaler_rst_out,
  output logic             feedback_divider_rst_out,
  output logic             input_divider_rst_out
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic       rst_sync_a;
  logic       rst_n;
  logic       startup_taken;
  logic [3:0] startup_value;
  logic [2:0] setup_pending;
  logic       lsb_active;
  logic       readback_sel;
  logic       update_bit;
  logic [7:0] power_ctrl;
  logic [7:0] pulse_reg;
  logic [7:0] held_reg;
  logic [7:0] next_rdata;
  logic       soft_reset;
  logic       update_now;
  logic       wr_setup;
  logic       wr_select;
  logic       wr_update;
  logic       wr_power;
  logic       wr_pulse;
  logic       wr_held;
  logic [3:0] setup_active_nibble;
  logic [3:0] setup_pending_nibble;
  logic       power_down_req;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_a <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_n      <= rst_sync_a;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = (addr == target);
  endfunction

  // Power-enable default built from startup straps
  function automatic logic [7:0] power_default(input logic [3:0] pins);
    power_default = {pins[0], pins[1], 1'b0, pins[2], 2'b00, 1'b0, pins[3]};
  endfunction

  // Upper nibble carries the same four bits in reverse order
  function automatic logic [7:0] mirror(input logic [3:0] low);
    mirror = {low[0], low[1], low[2], low[3], low};
  endfunction

  assign soft_reset = setup_pending[sync_regs_pkg::SETUP_SOFT_BIT];
  assign wr_setup   = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_SERIAL_PORT_SETUP);
  assign wr_select  = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_READBACK_SELECT);
  assign wr_update  = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_UPDATE_TRIGGER);
  assign wr_power   = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_POWER_ENABLE_CTRL);
  assign wr_pulse   = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_PULSE_RESETS);
  assign wr_held    = reg_write_in && hit(reg_addr_in, sync_regs_pkg::ADDR_HELD_RESETS);
  // Pin event or stored trigger bit give the same transfer
  assign update_now = update_pin_in | update_bit;

  // ****************************************************************
  // Startup strap capture
  // ****************************************************************
  // Caught once after hard reset release; soft reset never resamples
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      startup_taken <= 1'b0;
      startup_value <= 4'h0;
    end else if (!startup_taken) begin
      startup_taken <= 1'b1;
      startup_value <= startup_pin_in;
    end
  end

  // ****************************************************************
  // Serial port setup
  // ****************************************************************
  // Stored in order {soft, lsb, sdo}; the long bit is a constant one
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      setup_pending <= sync_regs_pkg::SETUP_RESET;
    end else if (wr_setup) begin
      // Bit 3 is ignored on write
      setup_pending <= reg_wdata_in[2:0];
    end
  end

  // Going to LSB first acts at once, back to MSB first waits for update
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lsb_active <= 1'b0;
    end else if (setup_pending[sync_regs_pkg::SETUP_LSB_BIT]) begin
      lsb_active <= 1'b1;
    end else if (update_now) begin
      lsb_active <= 1'b0;
    end
  end

  assign setup_active_nibble = {1'b1, setup_pending[2], lsb_active, setup_pending[0]};
  assign setup_pending_nibble = {1'b1, setup_pending};

  // ****************************************************************
  // Readback select and update trigger
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      readback_sel <= 1'b0;
    end else if (soft_reset) begin
      readback_sel <= 1'b0;
    end else if (wr_select) begin
      readback_sel <= reg_wdata_in[0];
    end
  end

  // Stored for one cycle, then clears by itself
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      update_bit <= 1'b0;
    end else if (soft_reset) begin
      update_bit <= 1'b0;
    end else begin
      update_bit <= wr_update && reg_wdata_in[0];
    end
  end

  // ****************************************************************
  // Power-down and enable
  // ****************************************************************
  // Default is taken from straps, so it is reloaded until they are caught
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      power_ctrl <= sync_regs_pkg::RESET_VALUE;
    end else if (!startup_taken) begin
      power_ctrl <= power_default(startup_pin_in);
    end else if (soft_reset) begin
      power_ctrl <= power_default(startup_value);
    end else if (wr_power) begin
      power_ctrl <= reg_wdata_in;
    end
  end

  // ****************************************************************
  // Reset strobes and held resets
  // ****************************************************************
  // Each written one lives exactly one cycle; bit 6 is reserved
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= sync_regs_pkg::RESET_VALUE;
    end else if (soft_reset) begin
      pulse_reg <= sync_regs_pkg::RESET_VALUE;
    end else if (wr_pulse) begin
      pulse_reg <= reg_wdata_in & sync_regs_pkg::PULSE_RESETS_MASK;
    end else begin
      pulse_reg <= sync_regs_pkg::RESET_VALUE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= sync_regs_pkg::RESET_VALUE;
    end else if (soft_reset) begin
      held_reg <= sync_regs_pkg::RESET_VALUE;
    end else if (wr_held) begin
      held_reg <= reg_wdata_in & sync_regs_pkg::HELD_RESETS_MASK;
    end
  end

  // ****************************************************************
  // Readback
  // ****************************************************************
  always_comb begin
    next_rdata = sync_regs_pkg::RESET_VALUE;
    case (reg_addr_in)
      sync_regs_pkg::ADDR_SERIAL_PORT_SETUP: begin
        // Bit 1 is buffered: pending or active copy by select
        if (readback_sel) begin
          next_rdata = mirror(setup_pending_nibble);
        end else begin
          next_rdata = mirror(setup_active_nibble);
        end
      end
      sync_regs_pkg::ADDR_CHIP_IDENT_LOW: begin
        next_rdata = sync_regs_pkg::CHIP_IDENT[7:0];
      end
      sync_regs_pkg::ADDR_CHIP_IDENT_HIGH: begin
        next_rdata = sync_regs_pkg::CHIP_IDENT[15:8];
      end
      sync_regs_pkg::ADDR_READBACK_SELECT: begin
        next_rdata = {7'h00, readback_sel};
      end
      sync_regs_pkg::ADDR_UPDATE_TRIGGER: begin
        next_rdata = {7'h00, update_bit};
      end
      sync_regs_pkg::ADDR_POWER_ENABLE_CTRL: begin
        next_rdata = power_ctrl;
      end
      sync_regs_pkg::ADDR_PULSE_RESETS: begin
        next_rdata = pulse_reg;
      end
      sync_regs_pkg::ADDR_HELD_RESETS: begin
        next_rdata = held_reg;
      end
      default: begin
        next_rdata = sync_regs_pkg::RESET_VALUE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out  <= sync_regs_pkg::RESET_VALUE;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Registered so that every strobe is glitch free toward analog blocks
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      update_pulse_out <= 1'b0;
    end else begin
      update_pulse_out <= update_now;
    end
  end

  // Level copy for the other banks, which restore their own defaults
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_reset;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sdo_enable_out <= 1'b0;
    end else begin
      sdo_enable_out <= setup_pending[sync_regs_pkg::SETUP_SDO_BIT];
    end
  end

  // Port logic follows the active order, never the pending one
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lsb_first_out <= 1'b0;
    end else begin
      lsb_first_out <= lsb_active;
    end
  end

  // Same effect as the pin: all but the serial port, clock stopped
  assign power_down_req = power_ctrl[sync_regs_pkg::PWR_FULL_PD_BIT] | power_down_pin_in;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      full_power_down_out   <= 1'b0;
      system_clock_stop_out <= 1'b0;
    end else begin
      full_power_down_out   <= power_down_req;
      system_clock_stop_out <= power_down_req;
    end
  end

  assign startup_latched_out        = startup_value;
  assign readback_pending_out       = readback_sel;
  assign diff_driver_pd_out         = power_ctrl[sync_regs_pkg::PWR_DIFF_PD_BIT];
  assign cmos_driver_en_out         = power_ctrl[sync_regs_pkg::PWR_CMOS_EN_BIT];
  // Doubler still needs its own enable in the output configuration
  assign doubler_power_out          = power_ctrl[sync_regs_pkg::PWR_DBL_EN_BIT];
  assign multiplier_pd_out          = power_ctrl[sync_regs_pkg::PWR_MULT_PD_BIT];
  assign reference_a_pd_out         = power_ctrl[sync_regs_pkg::PWR_REFERENCE_A_PD_BIT];
  assign reference_b_pd_out         = power_ctrl[sync_regs_pkg::PWR_REFERENCE_B_PD_BIT];
  // Bias stays on, only clocks are removed, so wake-up is quick
  assign digital_clock_gate_out     = power_ctrl[sync_regs_pkg::PWR_DIG_PD_BIT];
  assign history_clear_out          = pulse_reg[7];
  assign interrupt_clear_out        = pulse_reg[5];
  assign fine_detector_rst_out      = pulse_reg[4];
  assign coarse_detector_rst_out    = pulse_reg[3];
  assign loop_filter_rst_out        = pulse_reg[2];
  assign comb_integrator_rst_out    = pulse_reg[1];
  assign synthesizer_rst_out        = pulse_reg[0];
  assign fundamental_pd_out         = held_reg[7];
  // Level held while set; prescalers use it as an asynchronous reset
  assign feedback_prescaler_rst_out = held_reg[3];
  assign input_prescaler_rst_out    = held_reg[2];
  // Divider side synchronises these to its own prescaler output
  assign feedback_divider_rst_out   = held_reg[1];
  assign input_divider_rst_out      = held_reg[0];

endmodule

// ---- verilog/sync_regs_pkg.sv ----
// Constants for the serial configuration, power-down and reset register group
//
// Contract
// - Serial setup bits 7:4 always read as a mirror of bits 3:0.
// - Long-instruction bit 3 is read-only one; only long instructions are supported.
// - Soft reset bit 2 returns every register except address 0x0000 to default.
// - Soft reset neither releases nor resamples startup pins; hard-reset values are kept.
// - Soft reset bit is not self-clearing; software must write it back to zero.
// - Bit 1 selects LSB first; returning to MSB first waits for an update.
// - Bit 0 set enables the separate data output pin; clear means three-wire.
// - Readback select at 0x0004 bit 0 chooses pending or active buffered values.
// - Writing 1 to 0x0005 bit 0 acts like the update pin, then self-clears.
// - Power-enable register 0x0010 default comes from the startup pins.
// - Bit 7 powers down differential driver; bit 6 powers up CMOS driver.
// - Bit 5 powers up the output doubler; it also needs its own enable.
// - Bit 4 powers down multiplier; bits 3 and 2 power down references.
// - Bit 1 acts as the power-down pin: all but serial port, clock stopped.
// - Bit 0 gates most digital clocks, keeps serial port and input bias alive.
// - At 0x0012 bit 7 clears tuning-word history, bit 5 clears interrupt logic.
// - Bits 4..0 reset fine detector, coarse detector, loop filter, comb, synthesizer.
// - At 0x0013 bit 7 powers down the fundamental output, spur outputs stay.
// - Bits 3 and 2 hold the feedback and input prescalers in reset.
// - Bits 1 and 0 reset integer dividers, synchronous to their own prescalers.
// - A buffered register value takes effect on a register update, except that LSB first takes effect at once.
package sync_regs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [15:0] ADDR_SERIAL_PORT_SETUP = 16'h0000;
  localparam logic [15:0] ADDR_CHIP_IDENT_LOW    = 16'h0002;
  localparam logic [15:0] ADDR_CHIP_IDENT_HIGH   = 16'h0003;
  localparam logic [15:0] ADDR_READBACK_SELECT   = 16'h0004;
  localparam logic [15:0] ADDR_UPDATE_TRIGGER    = 16'h0005;
  localparam logic [15:0] ADDR_POWER_ENABLE_CTRL = 16'h0010;
  localparam logic [15:0] ADDR_PULSE_RESETS      = 16'h0012;
  localparam logic [15:0] ADDR_HELD_RESETS       = 16'h0013;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SETUP_LONG_BIT  = 3;
  localparam int SETUP_SOFT_BIT  = 2;
  localparam int SETUP_LSB_BIT   = 1;
  localparam int SETUP_SDO_BIT   = 0;
  localparam int PWR_DIFF_PD_BIT = 7;
  localparam int PWR_CMOS_EN_BIT = 6;
  localparam int PWR_DBL_EN_BIT  = 5;
  localparam int PWR_MULT_PD_BIT = 4;
  localparam int PWR_REFERENCE_A_PD_BIT = 3;
  localparam int PWR_REFERENCE_B_PD_BIT = 2;
  localparam int PWR_FULL_PD_BIT = 1;
  localparam int PWR_DIG_PD_BIT  = 0;

  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] PULSE_RESETS_MASK = 8'hbf;
  localparam logic [7:0] HELD_RESETS_MASK  = 8'h8f;
  localparam logic [7:0] RESET_VALUE       = 8'h00;
  localparam logic [2:0] SETUP_RESET       = 3'h0;
  // Identification value is arbitrary
  localparam logic [15:0] CHIP_IDENT       = 16'h5a01;

endpackage

// ---- tb/sync_regs_sva.sv ----
// Assertion checker for the serial configuration, power and reset register group
`timescale 1ns/1ps

module sync_regs_sva (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        update_pin_in,
  input wire logic        power_down_pin_in,
  input wire logic [3:0]  startup_latched_out,
  input wire logic        update_pulse_out,
  input wire logic        soft_reset_out,
  input wire logic        lsb_first_out,
  input wire logic        full_power_down_out,
  input wire logic        system_clock_stop_out,
  input wire logic        history_clear_out,
  input wire logic        interrupt_clear_out,
  input wire logic        fine_detector_rst_out,
  input wire logic        synthesizer_rst_out,
  input wire logic        fundamental_pd_out,
  input wire logic        input_divider_rst_out
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic pulse_wr;
  assign pulse_wr = reg_write_in && reg_addr_in == 16'h0012;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_pin_update: assert property (update_pin_in |=> update_pulse_out)
    else $error("update pin gave no update pulse");
  chk_pd_pin: assert property (
    power_down_pin_in |=> full_power_down_out && system_clock_stop_out)
    else $error("power-down pin not followed");
  chk_hist_cause: assert property (
    history_clear_out |-> $past(pulse_wr && reg_wdata_in[7]))
    else $error("history clear without its write");
  chk_irq_cause: assert property (
    interrupt_clear_out |-> $past(pulse_wr && reg_wdata_in[5]))
    else $error("interrupt clear without its write");
  chk_fine_cause: assert property (
    fine_detector_rst_out |-> $past(pulse_wr && reg_wdata_in[4]))
    else $error("fine detector reset without its write");
  chk_dds_self_clear: assert property (
    synthesizer_rst_out && !pulse_wr |=> !synthesizer_rst_out)
    else $error("synthesizer reset did not clear");
  chk_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_setup_mirror: assert property (
    reg_rvalid_out && $past(reg_addr_in) == 16'h0000 |-> reg_rdata_out[3] &&
    reg_rdata_out[7:4] == {reg_rdata_out[0], reg_rdata_out[1], reg_rdata_out[2],
    reg_rdata_out[3]})
    else $error("setup byte not mirrored");
  chk_spare_zero: assert property (
    reg_rvalid_out && $past(reg_addr_in) inside {16'h0001, 16'h0011}
    |-> reg_rdata_out == 8'h00)
    else $error("spare register not zero");
  chk_lsb_now: assert property (
    reg_write_in && reg_addr_in == 16'h0000 && reg_wdata_in[1] |-> ##3 lsb_first_out)
    else $error("lsb first not applied");
  chk_msb_waits: assert property (
    $fell(lsb_first_out) |-> $past(update_pulse_out) || $past(update_pulse_out, 2)
    || $past(update_pulse_out, 3))
    else $error("msb first without update");
  chk_soft_hold: assert property (
    soft_reset_out && $past(soft_reset_out) |-> !fundamental_pd_out && !input_divider_rst_out)
    else $error("register not held during soft reset");
  chk_strap_keep: assert property (soft_reset_out |=> $stable(startup_latched_out))
    else $error("straps changed during soft reset");
endmodule

bind serial_config_power_reset_regs sync_regs_sva u_sva (.clk_in, .reset_n_in, .reg_write_in,
  .reg_read_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .update_pin_in,
  .power_down_pin_in, .startup_latched_out, .update_pulse_out, .soft_reset_out,
  .lsb_first_out, .full_power_down_out, .system_clock_stop_out, .history_clear_out,
  .interrupt_clear_out, .fine_detector_rst_out, .synthesizer_rst_out, .fundamental_pd_out,
  .input_divider_rst_out);

// ---- tb/tb.sv ----
// Self-checking testbench for the serial configuration, power and reset register group
`timescale 1ns/1ps

module tb;
  logic        clk_in;
  logic        reset_n_in;
  logic        reg_write_in;
  logic        reg_read_in;
  logic [15:0] reg_addr_in;
  logic [7:0]  reg_wdata_in;
  logic [7:0]  reg_rdata_out;
  logic        reg_rvalid_out;
  logic        update_pin_in;
  logic        power_down_pin_in;
  logic [3:0]  startup_pin_in;
  logic [3:0]  startup_latched_out;
  logic        update_pulse_out;
  logic        soft_reset_out;
  logic        lsb_first_out;
  logic        sdo_enable_out;
  logic        system_clock_stop_out;
  logic        readback_pending_out;
  wire  [7:0]  pwr;
  wire  [6:0]  pls;
  wire  [4:0]  hld;
  logic [7:0]  d;
  logic        seen;
  int          n_mismatch = 0;
  int          comparisons = 0;

  serial_config_power_reset_regs dut (.clk_in, .reset_n_in, .reg_write_in, .reg_read_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .update_pin_in,
    .power_down_pin_in, .startup_pin_in, .startup_latched_out, .update_pulse_out,
    .readback_pending_out, .soft_reset_out, .lsb_first_out, .sdo_enable_out,
    .diff_driver_pd_out(pwr[7]), .cmos_driver_en_out(pwr[6]), .doubler_power_out(pwr[5]),
    .multiplier_pd_out(pwr[4]), .reference_a_pd_out(pwr[3]), .reference_b_pd_out(pwr[2]),
    .full_power_down_out(pwr[1]), .system_clock_stop_out, .digital_clock_gate_out(pwr[0]),
    .history_clear_out(pls[6]), .interrupt_clear_out(pls[5]), .fine_detector_rst_out(pls[4]),
    .coarse_detector_rst_out(pls[3]), .loop_filter_rst_out(pls[2]),
    .comb_integrator_rst_out(pls[1]), .synthesizer_rst_out(pls[0]),
    .fundamental_pd_out(hld[4]), .feedback_prescaler_rst_out(hld[3]),
    .input_prescaler_rst_out(hld[2]), .feedback_divider_rst_out(hld[1]),
    .input_divider_rst_out(hld[0]));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    tick(1);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = v;
    tick(1);
    reg_write_in = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    tick(1);
    reg_read_in = 1'b1;
    reg_addr_in = a;
    tick(1);
    reg_read_in = 1'b0;
    chk("read valid", 8'h01, {7'h00, reg_rvalid_out});
    chk(what, exp, reg_rdata_out);
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_mismatch++;
    results();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    reset_n_in = 1'b0;
    {reg_write_in, reg_read_in, update_pin_in, power_down_pin_in} = 4'h0;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 8'h00;
    startup_pin_in = 4'hb;
    repeat (8) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    tick(4);
    chk("straps", 8'h0b, {4'h0, startup_latched_out});
    rd(16'h0000, 8'h18, "setup default");
    rd(16'h0002, sync_regs_pkg::CHIP_IDENT[7:0], "ident low");
    wr(16'h0003, 8'h00);
    rd(16'h0003, sync_regs_pkg::CHIP_IDENT[15:8], "ident high");
    rd(16'h0010, 8'hc1, "power default");
    chk("power outputs", 8'hc1, pwr);
    foreach (d[i]) begin
      if (i < 3) begin
        wr(i == 0 ? 16'h0001 : (i == 1 ? 16'h0011 : 16'h0006), 8'hff);
        rd(i == 0 ? 16'h0001 : (i == 1 ? 16'h0011 : 16'h0006), 8'h00, "spare");
      end
    end
    for (int i = 0; i < 8; i++) begin
      wr(sync_regs_pkg::ADDR_POWER_ENABLE_CTRL, 8'h01 << i);
      tick(1);
      chk("power bits", 8'h01 << i, pwr);
      chk("clock stop", {7'h00, i == 1}, {7'h00, system_clock_stop_out});
    end
    wr(sync_regs_pkg::ADDR_POWER_ENABLE_CTRL, 8'h00);
    power_down_pin_in = 1'b1;
    tick(2);
    chk("pin power down", 8'h03, {6'h00, pwr[1], system_clock_stop_out});
    power_down_pin_in = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 8'h01 << i;
      wr(sync_regs_pkg::ADDR_PULSE_RESETS, d);
      chk("reset pulses", {1'b0, d[7], d[5:0]}, {1'b0, pls});
      tick(1);
      chk("pulses cleared", 8'h00, {1'b0, pls});
    end
    wr(sync_regs_pkg::ADDR_PULSE_RESETS, 8'h1f);
    chk("relock pulses", 8'h1f, {1'b0, pls});
    rd(sync_regs_pkg::ADDR_PULSE_RESETS, 8'h00, "pulse register");
    wr(sync_regs_pkg::ADDR_HELD_RESETS, 8'hff);
    tick(3);
    chk("held resets", 8'h1f, {3'h0, hld});
    rd(sync_regs_pkg::ADDR_HELD_RESETS, 8'h8f, "held register");
    // Upper nibble of a setup write must be ignored, the mirror wins
    wr(16'h0000, 8'hf1);
    tick(2);
    chk("four wire", 8'h01, {7'h00, sdo_enable_out});
    rd(16'h0000, 8'h99, "setup four wire");
    wr(16'h0000, 8'h03);
    tick(2);
    chk("lsb first", 8'h01, {7'h00, lsb_first_out});
    wr(16'h0000, 8'h01);
    tick(4);
    chk("msb waits", 8'h01, {7'h00, lsb_first_out});
    rd(16'h0000, 8'hdb, "active order");
    wr(sync_regs_pkg::ADDR_READBACK_SELECT, 8'h01);
    chk("pending output", 8'h01, {7'h00, readback_pending_out});
    rd(16'h0000, 8'h99, "pending order");
    rd(sync_regs_pkg::ADDR_READBACK_SELECT, 8'h01, "readback select");
    wr(sync_regs_pkg::ADDR_READBACK_SELECT, 8'h00);
    wr(sync_regs_pkg::ADDR_UPDATE_TRIGGER, 8'h01);
    seen = 1'b0;
    for (int k = 0; k < 4; k++) begin
      seen = seen | update_pulse_out;
      tick(1);
    end
    chk("trigger update", 8'h01, {7'h00, seen});
    chk("msb after update", 8'h00, {7'h00, lsb_first_out});
    rd(sync_regs_pkg::ADDR_UPDATE_TRIGGER, 8'h00, "trigger cleared");
    update_pin_in = 1'b1;
    tick(1);
    update_pin_in = 1'b0;
    chk("pin update", 8'h01, {7'h00, update_pulse_out});
    // Soft reset with non-default contents and changed straps
    wr(sync_regs_pkg::ADDR_HELD_RESETS, 8'h80);
    wr(sync_regs_pkg::ADDR_READBACK_SELECT, 8'h01);
    startup_pin_in = 4'h0;
    wr(16'h0000, 8'h05);
    tick(2);
    chk("soft reset", 8'h01, {7'h00, soft_reset_out});
    rd(sync_regs_pkg::ADDR_HELD_RESETS, 8'h00, "held after soft");
    rd(sync_regs_pkg::ADDR_POWER_ENABLE_CTRL, 8'hc1, "power after soft");
    rd(sync_regs_pkg::ADDR_READBACK_SELECT, 8'h00, "select after soft");
    rd(16'h0000, 8'hbd, "setup kept");
    wr(sync_regs_pkg::ADDR_HELD_RESETS, 8'h80);
    rd(sync_regs_pkg::ADDR_HELD_RESETS, 8'h00, "write in soft");
    chk("soft stays", 8'h01, {7'h00, soft_reset_out});
    chk("straps kept", 8'h0b, {4'h0, startup_latched_out});
    wr(16'h0000, 8'h01);
    tick(2);
    chk("soft cleared", 8'h00, {7'h00, soft_reset_out});
    rd(sync_regs_pkg::ADDR_POWER_ENABLE_CTRL, 8'hc1, "power no resample");
    results();
  end
endmodule
